// [rtl/offset_cal_pkg.sv]
// Purpose: Shared constants and carriers for the offset calibration and trim control block
// Assumes: 200 MHz system clock, APB register access with 32-bit data
// Notes: Register offsets are byte addresses on the APB bus
package offset_cal_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CORE_CAL_NS = 1000;
  localparam int OFFSET_CAL_NS = 500;
  localparam int BG_STEP_NS = 2000;
  localparam int CORE_CAL_CYC = (CORE_CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int OFFSET_CAL_CYC = (OFFSET_CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int BG_STEP_CYC = (BG_STEP_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 10;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_NOTCH = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_TRIM_AA = 12'h00C;
  localparam logic [11:0] ADDR_TRIM_AB = 12'h010;
  localparam logic [11:0] ADDR_TRIM_BA = 12'h014;
  localparam logic [11:0] ADDR_TRIM_BB = 12'h018;
  localparam logic [11:0] ADDR_TRIM_C = 12'h01C;
  localparam logic [11:0] ADDR_CORE_TIME = 12'h020;
  localparam logic [11:0] ADDR_SINGLE_TIME = 12'h024;
  localparam logic [11:0] ADDR_BANK_TIME = 12'h028;

  localparam logic [1:0] CORE_A = 2'h0;
  localparam logic [1:0] CORE_B = 2'h1;
  localparam logic [1:0] CORE_SPARE = 2'h2;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [15:0] TIME_RST = 16'h0000;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_CORE, ST_OFFS} cal_state_t;

  // Bit 0 is the last field
  typedef struct packed {
    logic single_channel;
    logic zero_freq_keep;
    logic offset_filter_en;
    logic cal_software_trigger;
    logic cal_trigger_source_sel;
    logic background_cal_en;
    logic bg_offset_cal_en;
    logic fg_offset_cal_en;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic [3:0] notch_settle;
    logic [3:0] notch_bandwidth;
  } notch_set_t;
  localparam notch_set_t NOTCH_RST = '0;

  typedef struct packed {
    logic half_en;
    logic quarter_en;
    logic zero_freq_keep;
    logic [3:0] notch_bandwidth;
    logic [3:0] notch_settle;
  } notch_cfg_t;

  typedef struct packed {
    logic signed [7:0] aa;
    logic signed [7:0] ab;
    logic signed [7:0] ba;
    logic signed [7:0] bb;
    logic signed [7:0] cc;
  } trim_set_t;

  typedef struct packed {
    logic signed [7:0] in_a;
    logic signed [7:0] in_b;
  } offset_meas_t;
endpackage

// [rtl/adc_offset_cal_trim_ctrl.sv]
// Purpose: Offset calibration sequencing, offset trim storage, timing trim routing, notch setup
// Assumes: offset_meas comes from the converter datapath on clk_sys; trigger pin is asynchronous
// Notes: Cal engine itself is outside; this block sequences it and owns the trims
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Run a separate calibration for input buffer offsets.
// - Foreground offset enable runs offset calibration once inside the foreground pass.
// - Background offset enable with background cal keeps correcting input offsets continuously.
// - Foreground offset enable with background cal gives one offset cal, no tracking.
// - Calibration writes offset trims; software writes refused while offset cal used.
// - Foreground plus background enables calibrate all three cores' offsets.
// - Zero-phase bank timing in dual mode and core B; -90 only core A single.
// - Either inter-core timing trim shifts core A relative to core B.
// - Offset filter notches half rate, plus quarter rate in single-input mode.
// - Zero-frequency keep selects retaining or removing DC content while filtering.
// - Smaller notch bandwidth narrows the notch.
// - Conversion halts during foreground calibration until it finishes.
// - Foreground cal starts from trigger pin or software bit, chosen by select bit.
module adc_offset_cal_trim_ctrl
  import offset_cal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_trigger_pin,
  input wire offset_meas_t offset_meas,
  output logic convert_halt,
  output logic core_cal_run,
  output logic [1:0] offset_core_sel,
  output logic foreground_done,
  output trim_set_t input_offset_trim,
  output notch_cfg_t notch_cfg,
  output logic [7:0] bank_time_a,
  output logic [7:0] bank_time_b,
  output logic signed [8:0] core_skew
);
  ctrl_t ctrl_q;
  notch_set_t notch_q;
  trim_set_t trims_q;
  logic [15:0] core_time_q, single_time_q, bank_time_q;
  cal_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, bg_cnt_q;
  logic [1:0] core_idx_q, bg_core_q, last_core;
  logic pass_os_q, start_pend_q, soft_trig_q, pin_s1_q, pin_s2_q, pin_s3_q;
  logic [31:0] rdata_d;
  logic wr_en, mapped, offs_in_use, bg_track, slot_end, start, pin_rise, soft_rise;
  logic halt_q, done_q, ready_q, err_q, core_run_q;
  logic [31:0] rdata_q;
  logic [1:0] osel_q;
  notch_cfg_t ncfg_q;
  logic [7:0] bta_q, btb_q;
  logic signed [8:0] skew_q;

  function automatic logic signed [7:0] neg8(input logic signed [7:0] v);
    neg8 = (v == -8'sd128) ? 8'sd127 : -v;
  endfunction

  // Single step toward cancelling the residual, saturating
  function automatic logic signed [7:0] step8(input logic signed [7:0] t,
                                              input logic signed [7:0] m);
    if (m > 0 && t != -8'sd128) begin
      step8 = t - 8'sd1;
    end else if (m < 0 && t != 8'sd127) begin
      step8 = t + 8'sd1;
    end else begin
      step8 = t;
    end
  endfunction

  // APB access phase always completes on its first cycle
  assign wr_en = psel && penable && pwrite && ready_q;
  assign offs_in_use = ctrl_q.fg_offset_cal_en || bg_track;
  assign bg_track = ctrl_q.bg_offset_cal_en && ctrl_q.background_cal_en;
  assign last_core = ctrl_q.background_cal_en ? CORE_SPARE : CORE_B;
  assign slot_end = (state_q == ST_OFFS) && (cnt_q == CNT_W'(OFFSET_CAL_CYC - 1));
  assign pin_rise = pin_s2_q && !pin_s3_q;
  assign soft_rise = ctrl_q.cal_software_trigger && !soft_trig_q;
  assign start = ctrl_q.cal_trigger_source_sel ? pin_rise : soft_rise;

  always_comb begin
    mapped = 1'b1;
    rdata_d = RDATA_ZERO;
    unique case (paddr)
      ADDR_CTRL: rdata_d = {24'h00_0000, ctrl_q};
      ADDR_NOTCH: rdata_d = {24'h00_0000, notch_q};
      ADDR_STATUS: rdata_d = {26'h000_0000, core_idx_q, bg_track, halt_q, done_q, 1'b0};
      ADDR_TRIM_AA: rdata_d = {24'h00_0000, trims_q.aa};
      ADDR_TRIM_AB: rdata_d = {24'h00_0000, trims_q.ab};
      ADDR_TRIM_BA: rdata_d = {24'h00_0000, trims_q.ba};
      ADDR_TRIM_BB: rdata_d = {24'h00_0000, trims_q.bb};
      ADDR_TRIM_C: rdata_d = {24'h00_0000, trims_q.cc};
      ADDR_CORE_TIME: rdata_d = {16'h0000, core_time_q};
      ADDR_SINGLE_TIME: rdata_d = {16'h0000, single_time_q};
      ADDR_BANK_TIME: rdata_d = {16'h0000, bank_time_q};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= RDATA_ZERO;
    end else begin
      ready_q <= psel && !penable;
      err_q <= psel && !penable && !mapped;
      if (psel && !penable) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      notch_q <= NOTCH_RST;
      core_time_q <= TIME_RST;
      single_time_q <= TIME_RST;
      bank_time_q <= TIME_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_q <= ctrl_t'(pwdata[7:0]);
      end
      if (paddr == ADDR_NOTCH) begin
        notch_q <= notch_set_t'(pwdata[7:0]);
      end
      if (paddr == ADDR_CORE_TIME) begin
        core_time_q <= pwdata[15:0];
      end
      if (paddr == ADDR_SINGLE_TIME) begin
        single_time_q <= pwdata[15:0];
      end
      if (paddr == ADDR_BANK_TIME) begin
        bank_time_q <= pwdata[15:0];
      end
    end
  end

  // Pin is asynchronous; edge detect only on synchronised copies
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      soft_trig_q <= 1'b0;
    end else begin
      pin_s1_q <= cal_trigger_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      soft_trig_q <= ctrl_q.cal_software_trigger;
    end
  end

  // Power-up pass is pending out of reset; a trigger during a pass is kept
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      start_pend_q <= 1'b1;
    end else if (start) begin
      start_pend_q <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      start_pend_q <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start_pend_q) state_d = ST_CORE;
      ST_CORE: begin
        if (cnt_q == CNT_W'(CORE_CAL_CYC - 1)) begin
          state_d = pass_os_q ? ST_OFFS : ST_IDLE;
        end
      end
      ST_OFFS: if (slot_end && core_idx_q == last_core) state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      core_idx_q <= CORE_A;
      pass_os_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q != state_d || slot_end) begin
        cnt_q <= '0;
      end else if (state_q != ST_IDLE) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
      if (state_q == ST_IDLE) begin
        core_idx_q <= CORE_A;
        pass_os_q <= ctrl_q.fg_offset_cal_en;
      end else if (slot_end && core_idx_q != last_core) begin
        core_idx_q <= core_idx_q + 2'd1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      halt_q <= 1'b0;
      done_q <= 1'b0;
      core_run_q <= 1'b0;
    end else begin
      halt_q <= state_d != ST_IDLE;
      core_run_q <= state_d == ST_CORE;
      if (state_q == ST_IDLE && state_d != ST_IDLE) begin
        done_q <= 1'b0;
      end else if (state_q != ST_IDLE && state_d == ST_IDLE) begin
        done_q <= 1'b1;
      end
    end
  end

  // Background tracking rotates through the cores, one step each tick
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bg_cnt_q <= '0;
      bg_core_q <= CORE_A;
    end else if (!bg_track || state_q != ST_IDLE) begin
      bg_cnt_q <= '0;
    end else if (bg_cnt_q == CNT_W'(BG_STEP_CYC - 1)) begin
      bg_cnt_q <= '0;
      bg_core_q <= (bg_core_q == CORE_SPARE) ? CORE_A : bg_core_q + 2'd1;
    end else begin
      bg_cnt_q <= bg_cnt_q + CNT_W'(1);
    end
  end

  logic bg_tick;
  assign bg_tick = bg_track && state_q == ST_IDLE && bg_cnt_q == CNT_W'(BG_STEP_CYC - 1);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trims_q <= '{TRIM_RST, TRIM_RST, TRIM_RST, TRIM_RST, TRIM_RST};
    end else if (slot_end) begin
      unique case (core_idx_q)
        CORE_A: begin
          trims_q.aa <= neg8(offset_meas.in_a);
          trims_q.ab <= neg8(offset_meas.in_b);
        end
        CORE_B: begin
          trims_q.ba <= neg8(offset_meas.in_a);
          trims_q.bb <= neg8(offset_meas.in_b);
        end
        default: trims_q.cc <= neg8(offset_meas.in_a);
      endcase
    end else if (bg_tick) begin
      unique case (bg_core_q)
        CORE_A: begin
          trims_q.aa <= step8(trims_q.aa, offset_meas.in_a);
          trims_q.ab <= step8(trims_q.ab, offset_meas.in_b);
        end
        CORE_B: begin
          trims_q.ba <= step8(trims_q.ba, offset_meas.in_a);
          trims_q.bb <= step8(trims_q.bb, offset_meas.in_b);
        end
        default: trims_q.cc <= step8(trims_q.cc, offset_meas.in_a);
      endcase
    end else if (wr_en && !offs_in_use) begin
      if (paddr == ADDR_TRIM_AA) trims_q.aa <= pwdata[7:0];
      if (paddr == ADDR_TRIM_AB) trims_q.ab <= pwdata[7:0];
      if (paddr == ADDR_TRIM_BA) trims_q.ba <= pwdata[7:0];
      if (paddr == ADDR_TRIM_BB) trims_q.bb <= pwdata[7:0];
      if (paddr == ADDR_TRIM_C) trims_q.cc <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osel_q <= CORE_A;
      ncfg_q <= '0;
      bta_q <= TRIM_RST;
      btb_q <= TRIM_RST;
      skew_q <= '0;
    end else begin
      osel_q <= (state_q == ST_OFFS) ? core_idx_q : bg_core_q;
      ncfg_q.half_en <= ctrl_q.offset_filter_en;
      ncfg_q.quarter_en <= ctrl_q.offset_filter_en && ctrl_q.single_channel;
      ncfg_q.zero_freq_keep <= ctrl_q.zero_freq_keep;
      ncfg_q.notch_bandwidth <= notch_q.notch_bandwidth;
      ncfg_q.notch_settle <= notch_q.notch_settle;
      bta_q <= ctrl_q.single_channel ? bank_time_q[15:8] : bank_time_q[7:0];
      btb_q <= bank_time_q[7:0];
      // Difference so either trim moves core A against core B
      skew_q <= ctrl_q.single_channel ?
        $signed({1'b0, single_time_q[7:0]}) - $signed({1'b0, single_time_q[15:8]}) :
        $signed({1'b0, core_time_q[7:0]}) - $signed({1'b0, core_time_q[15:8]});
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign convert_halt = halt_q;
  assign core_cal_run = core_run_q;
  assign offset_core_sel = osel_q;
  assign foreground_done = done_q;
  assign input_offset_trim = trims_q;
  assign notch_cfg = ncfg_q;
  assign bank_time_a = bta_q;
  assign bank_time_b = btb_q;
  assign core_skew = skew_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_halt_during_pass: assert property ((state_q != ST_IDLE) |-> convert_halt)
    else $error("conversion not halted during calibration");
  chk_done_clears_start: assert property ($rose(convert_halt) |-> !foreground_done)
    else $error("done not cleared at pass start");
  chk_done_sets_end: assert property ($fell(convert_halt) |-> foreground_done)
    else $error("done not set at pass end");
  chk_core_phase_len: assert property ((state_q == ST_CORE) |-> cnt_q < CNT_W'(CORE_CAL_CYC))
    else $error("core phase overran");
  chk_offs_needs_enable: assert property ((state_q == ST_OFFS) |-> pass_os_q)
    else $error("offset phase without enable");
  chk_offs_all_cores: assert property (
    (slot_end && core_idx_q == CORE_B && ctrl_q.background_cal_en) |=> (state_q == ST_OFFS)
      ##0 (core_idx_q == CORE_SPARE))
    else $error("spare core skipped");
  chk_trim_write_block: assert property ((wr_en && offs_in_use && state_q == ST_IDLE
    && !bg_tick) |=> $stable(trims_q))
    else $error("trim written while offset cal in use");
  chk_trim_write_take: assert property ((wr_en && paddr == ADDR_TRIM_AA && !offs_in_use
    && !slot_end && !bg_tick) |=> trims_q.aa == $past(pwdata[7:0]))
    else $error("trim write lost");
  chk_bank_phase_sel: assert property (1'b1 |=> bank_time_a == ($past(ctrl_q.single_channel)
    ? $past(bank_time_q[15:8]) : $past(bank_time_q[7:0])))
    else $error("wrong bank timing phase");
  chk_quarter_notch: assert property (notch_cfg.quarter_en |-> notch_cfg.half_en)
    else $error("quarter notch without half notch");
  chk_apb_ready: assert property ((psel && !penable) |=> pready ##1 !pready)
    else $error("apb ready timing");
  chk_no_track_fg: assert property ((!bg_track && state_q == ST_IDLE && !wr_en)
    |=> $stable(trims_q))
    else $error("trims drifted without tracking");

  cov_three_core_pass: cover property (slot_end && core_idx_q == CORE_SPARE);
  cov_bg_step: cover property (bg_tick);
  cov_pin_start: cover property (ctrl_q.cal_trigger_source_sel && pin_rise);
  cov_refused_write: cover property (wr_en && offs_in_use && paddr == ADDR_TRIM_BB);
endmodule
`default_nettype wire

// [tb/test_adc_offset_cal_trim_ctrl.sv]
// Purpose: Self-checking bench for the offset calibration and trim control block
// Assumes: 0-wait APB slave, power-up pass right after reset release
// Notes: Pass lengths derived from package cycle constants
`timescale 1ns/1ps
`default_nettype none
module test_adc_offset_cal_trim_ctrl
  import offset_cal_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] wd;
    logic [31:0] rd;
    logic err;
  } row_t;
  logic clk_sys, rst_b, psel, penable, pwrite, cal_trigger_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, convert_halt, core_cal_run, foreground_done;
  logic [1:0] offset_core_sel;
  offset_meas_t offset_meas;
  trim_set_t input_offset_trim;
  notch_cfg_t notch_cfg;
  logic [7:0] bank_time_a, bank_time_b, aa0;
  logic signed [8:0] core_skew;
  int fail_count, checked, n, m;
  logic [1:0] sel;
  // Unmapped row last; reads must come back zero with an error
  row_t rows [0:5] = '{
    '{ADDR_NOTCH, 32'h0000_0033, 32'h0000_0033, 1'b0},
    '{ADDR_CORE_TIME, 32'h0000_0510, 32'h0000_0510, 1'b0},
    '{ADDR_SINGLE_TIME, 32'h0000_2040, 32'h0000_2040, 1'b0},
    '{ADDR_BANK_TIME, 32'h0000_7F11, 32'h0000_7F11, 1'b0},
    '{ADDR_TRIM_AA, 32'h0000_0012, 32'h0000_0012, 1'b0},
    '{12'h040, 32'h0000_00AA, 32'h0000_0000, 1'b1}};

  adc_offset_cal_trim_ctrl DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_trigger_pin(cal_trigger_pin), .offset_meas(offset_meas),
    .convert_halt(convert_halt), .core_cal_run(core_cal_run),
    .offset_core_sel(offset_core_sel), .foreground_done(foreground_done),
    .input_offset_trim(input_offset_trim), .notch_cfg(notch_cfg),
    .bank_time_a(bank_time_a), .bank_time_b(bank_time_b), .core_skew(core_skew));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Held until the rising edge that samples pready high; data taken there
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 50) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts halt and core-phase cycles of one pass, highest core offered; bounded
  task automatic pass_len(output int cnt, output int ccnt, output logic [1:0] smax);
    int k;
    logic seen;
    cnt = 0;
    ccnt = 0;
    smax = CORE_A;
    seen = 1'b0;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk_sys);
      if (convert_halt === 1'b1) begin
        seen = 1'b1;
        cnt++;
        if (core_cal_run === 1'b1) ccnt++;
        if (offset_core_sel > smax) smax = offset_core_sel;
      end else if (seen) break;
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  initial begin
    fail_count = 0;
    checked = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cal_trigger_pin = 1'b0;
    offset_meas = 16'h05FD;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check({30'h0, convert_halt, foreground_done}, 32'h0000_0000);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    pass_len(n, m, sel);
    check(32'(n), 32'(CORE_CAL_CYC));
    check(32'(m), 32'(CORE_CAL_CYC));
    check({30'h0, sel}, {30'h0, CORE_A});
    check({31'h0, foreground_done}, 32'h0000_0001);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      check({31'h0, err}, {31'h0, rows[i].err});
      apb(1'b0, rows[i].a, 32'h0000_0000);
      check(rd, rows[i].rd);
      check({31'h0, err}, {31'h0, rows[i].err});
    end
    settle();
    check({16'h0, bank_time_a, bank_time_b}, 32'h0000_1111);
    check(32'(core_skew), 32'h0000_000B);
    check({21'h0, notch_cfg}, 32'h0000_0033);
    apb(1'b1, ADDR_CTRL, 32'h0000_00E0);
    settle();
    check({16'h0, bank_time_a, bank_time_b}, 32'h0000_7F11);
    check(32'(core_skew), 32'h0000_0020);
    check({29'h0, notch_cfg[10:8]}, 32'h0000_0007);
    apb(1'b1, ADDR_CTRL, 32'h0000_0020);
    settle();
    check({29'h0, notch_cfg[10:8]}, 32'h0000_0004);
    // Foreground pass with offset cal on cores A and B only
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0000_0011);
    pass_len(n, m, sel);
    check(32'(n), 32'(CORE_CAL_CYC + 2 * OFFSET_CAL_CYC));
    check(32'(m), 32'(CORE_CAL_CYC));
    check({30'h0, sel}, {30'h0, CORE_B});
    check({31'h0, foreground_done}, 32'h0000_0001);
    check(input_offset_trim[39:8], 32'hFB03_FB03);
    check({24'h0, input_offset_trim.cc}, 32'h0000_0000);
    apb(1'b1, ADDR_TRIM_AA, 32'h0000_0007);
    apb(1'b0, ADDR_TRIM_AA, 32'h0000_0000);
    check(rd, 32'h0000_00FB);
    // Foreground offset with background selected covers the spare core
    offset_meas <= 16'h0902;
    apb(1'b1, ADDR_CTRL, 32'h0000_0005);
    apb(1'b1, ADDR_CTRL, 32'h0000_0015);
    pass_len(n, m, sel);
    check(32'(n), 32'(CORE_CAL_CYC + 3 * OFFSET_CAL_CYC));
    check({30'h0, sel}, {30'h0, CORE_SPARE});
    check({24'h0, input_offset_trim.cc}, 32'h0000_00F7);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0002);
    aa0 = input_offset_trim.aa;
    repeat (900) @(posedge clk_sys);
    @(negedge clk_sys);
    check({24'h0, input_offset_trim.aa}, {24'h0, aa0});
    // Pin selected: software edge ignored, pin edge starts a pass
    apb(1'b1, ADDR_CTRL, 32'h0000_0008);
    apb(1'b1, ADDR_CTRL, 32'h0000_0018);
    repeat (20) @(negedge clk_sys);
    check({31'h0, convert_halt}, 32'h0000_0000);
    @(posedge clk_sys);
    cal_trigger_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cal_trigger_pin <= 1'b0;
    pass_len(n, m, sel);
    check(32'(n), 32'(CORE_CAL_CYC));
    check(32'(m), 32'(CORE_CAL_CYC));
    // Background tracking steps trim toward cancelling the residual
    offset_meas <= 16'h0502;
    apb(1'b1, ADDR_CTRL, 32'h0000_0006);
    aa0 = input_offset_trim.aa;
    apb(1'b1, ADDR_TRIM_AA, 32'h0000_0033);
    repeat (1300) @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h0, $signed(input_offset_trim.aa) < $signed(aa0)}, 32'h0000_0001);
    check({31'h0, convert_halt}, 32'h0000_0000);
    // Trims are not read while tracking; status only
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_000A);
    // Reset mid-run clears trims and status, then a fresh power-up pass runs
    @(posedge clk_sys);
    rst_b <= 1'b0;
    settle();
    check(input_offset_trim[39:8], 32'h0000_0000);
    check({30'h0, convert_halt, foreground_done}, 32'h0000_0000);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    pass_len(n, m, sel);
    check(32'(n), 32'(CORE_CAL_CYC));
    check({31'h0, foreground_done}, 32'h0000_0001);
    end_sim();
  end

  // Tests take about 3900 cycles; generous margin
  initial begin
    #200us;
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
